// [rtl/cmp_ctl_pkg.sv]
package cmp_ctl_pkg;
	// register byte addresses on the bus
	localparam logic [7:0] OFS_CONTROL   = 8'h00;
	localparam logic [7:0] OFS_FLAGS     = 8'h04;
	localparam logic [7:0] OFS_ENABLES   = 8'h08;
	localparam logic [7:0] OFS_MASTER    = 8'h0C;
	localparam logic [7:0] OFS_DIRECTION = 8'h10;
	localparam logic [7:0] OFS_LATCH     = 8'h14;
	localparam logic [7:0] OFS_ANALOG    = 8'h18;
	localparam logic [7:0] OFS_PORT_READ = 8'h1C;

	// comparator_control field positions
	localparam int CTL_B_RESULT = 7;
	localparam int CTL_A_RESULT = 6;
	localparam int CTL_B_INVERT = 5;
	localparam int CTL_A_INVERT = 4;
	localparam int CTL_IN_SWITCH = 3;
	localparam int CTL_MODE_HI  = 2;

	// interrupt bit positions
	localparam int FLAG_BIT       = 6;
	localparam int PERIPH_EN_BIT  = 6;
	localparam int GLOBAL_EN_BIT  = 7;

	// port pins that carry the comparator results
	localparam int PIN_A_OUT = 1;
	localparam int PIN_B_OUT = 2;

	// reset values
	localparam logic [5:0] CTL_RESET       = 6'h07;
	localparam logic [7:0] DIRECTION_RESET = 8'hFE;
	localparam logic [7:0] ANALOG_RESET    = 8'h7E;

	// mode encodings
	localparam logic [2:0] MODE_MUX_FOUR  = 3'h6;
	localparam logic [2:0] MODE_OFF       = 3'h7;
	localparam logic [2:0] MODE_ROUTE_ONE = 3'h3;
	localparam logic [2:0] MODE_ROUTE_TWO = 3'h5;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [rtl/cmp_det_if.sv]
`timescale 1ns/1ps
// carries raw results in, conditioned results and mismatch out
interface cmp_det_if;
	logic [1:0] raw;
	logic [1:0] invert;
	logic       snap_take;
	logic [1:0] result;
	logic       mismatch;
	modport det (input raw, input invert, input snap_take, output result, output mismatch);
	modport ctl (output raw, output invert, output snap_take, input result, input mismatch);
endinterface

// [rtl/cmp_change_detect.sv]
`timescale 1ns/1ps
// synchronises the comparator results and flags a difference from the last snapshot
module cmp_change_detect (
	// clock and reset
	input wire logic MCLK,
	input wire logic RESET_N,
	// link to the control block
	cmp_det_if.det   dif
);
	logic [1:0] sync1_reg;
	logic [1:0] sync2_reg;
	logic [1:0] snap_reg;

	// two-stage synchroniser; first stage feeds only the second
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			sync1_reg <= 2'h0;
			sync2_reg <= 2'h0;
		end else begin
			sync1_reg <= dif.raw;
			sync2_reg <= sync1_reg;
		end
	end

	// polarity applied after the crossing so an invert change is seen as a change too
	assign dif.result = sync2_reg ^ dif.invert;

	// snapshot taken on every control register access; a change in that very
	// cycle still differs from the old snapshot and sets the flag all the same
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			snap_reg <= 2'h0;
		end else if (dif.snap_take) begin
			snap_reg <= dif.result;
		end
	end

	assign dif.mismatch = (snap_reg != dif.result);
endmodule

// [rtl/cmp_ctl_top.sv]
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - result bit set when plus input exceeds minus
// - bits 5 and 4 invert comparator b and a
// - bits 7 and 6 show results, read-only
// - bits 2 to 0 select eight modes
// - mode 110: input switch picks minus pins
// - internal reference to plus inputs, mode 110
// - routing modes drive two pins, unsynchronized results
// - direction bits still enable those pins
// - analog pins read back as zero
// - any result change sets the flag
// - software writes zero clears, one sets flag
// - request needs three enables; flag sets regardless
// - change during access may not set flag; this design still sets it
// - control access ends the mismatch condition
// - persisting mismatch keeps setting the flag
// - reset puts mode at 111, comparators off
module cmp_ctl_top
	import cmp_ctl_pkg::*;
(
	// clock and reset
	input  wire logic        MCLK,
	input  wire logic        RESET_N,
	// axi4-lite write address and data
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	// axi4-lite write response
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	// axi4-lite read
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	// analog comparator results, asynchronous
	input  wire logic        CMP_A_RAW,
	input  wire logic        CMP_B_RAW,
	// analog switch controls
	output logic             CMP_A_ON,
	output logic             CMP_B_ON,
	output logic [2:0]       MODE_SEL,
	output logic             INPUT_SWITCH,
	output logic             REF_TO_PLUS,
	// port f pins
	input  wire logic [7:0]  PORT_F_IN,
	output logic [7:0]       PORT_F_OUT,
	output logic [7:0]       PORT_F_OE,
	// interrupt request to the processor
	output logic             CMP_IRQ_REQ
);
	logic [5:0] ctl_reg;
	logic       flag_reg;
	logic       cmp_en_reg;
	logic [1:0] master_reg;
	logic [7:0] dir_reg;
	logic [7:0] latch_reg;
	logic [7:0] analog_reg;
	logic       wr_fire;
	logic       rd_fire;
	logic       ctl_access;
	logic [7:0] wbyte;
	logic [7:0] rd_next;
	logic       rd_hit;
	logic       wr_hit;
	logic       route_on;
	logic [7:0] pin_drive;

	cmp_det_if dif ();

	cmp_change_detect u_det (
		.MCLK    (MCLK),
		.RESET_N (RESET_N),
		.dif     (dif)
	);

	// does this mode route the results onto the port pins
	function automatic logic mode_routes(input logic [2:0] m);
		return (m == MODE_ROUTE_ONE) || (m == MODE_ROUTE_TWO);
	endfunction

	// register offsets that answer on the bus
	function automatic logic addr_mapped(input logic [7:0] a);
		return (a == OFS_CONTROL) || (a == OFS_FLAGS) || (a == OFS_ENABLES)
			|| (a == OFS_MASTER) || (a == OFS_DIRECTION) || (a == OFS_LATCH)
			|| (a == OFS_ANALOG) || (a == OFS_PORT_READ);
	endfunction

	// handshakes: both write channels are held ready together, so order is moot
	assign wr_fire = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;
	assign wbyte   = S_AXI_WDATA[7:0];
	assign wr_hit  = wr_fire && S_AXI_WSTRB[0];
	assign ctl_access = (wr_fire && S_AXI_AWADDR == OFS_CONTROL)
		|| (rd_fire && S_AXI_ARADDR == OFS_CONTROL);

	assign dif.raw       = {CMP_B_RAW, CMP_A_RAW};
	assign dif.invert    = ctl_reg[CTL_B_INVERT:CTL_A_INVERT];
	assign dif.snap_take = ctl_access;

	// write channel readiness waits for both address and data
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY  <= 1'b0;
		end else if (wr_fire) begin
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY  <= 1'b0;
		end else if (S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID) begin
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY  <= 1'b1;
		end
	end

	// write response, slverr for unmapped offsets
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= RESP_OKAY;
		end else if (wr_fire) begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP  <= addr_mapped(S_AXI_AWADDR) ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	// read address acceptance, one read outstanding
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			S_AXI_ARREADY <= 1'b0;
		end else if (rd_fire) begin
			S_AXI_ARREADY <= 1'b0;
		end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
			S_AXI_ARREADY <= 1'b1;
		end
	end

	// read data mux; result bits come live from the synchroniser
	// so a read always shows the level the change detector compares against
	always_comb begin
		rd_next = 8'h00;
		rd_hit  = 1'b1;
		unique case (S_AXI_ARADDR)
			OFS_CONTROL:   rd_next = {dif.result, ctl_reg};
			OFS_FLAGS:     rd_next = 8'(flag_reg) << FLAG_BIT;
			OFS_ENABLES:   rd_next = 8'(cmp_en_reg) << PERIPH_EN_BIT;
			OFS_MASTER:    rd_next = {master_reg, 6'h00};
			OFS_DIRECTION: rd_next = dir_reg;
			OFS_LATCH:     rd_next = latch_reg;
			OFS_ANALOG:    rd_next = analog_reg;
			OFS_PORT_READ: rd_next = PORT_F_IN & ~analog_reg;
			default:       rd_hit  = 1'b0;
		endcase
	end

	// read response holds until the master takes it
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= 32'h00000000;
			S_AXI_RRESP  <= RESP_OKAY;
		end else if (rd_fire) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA  <= {24'h000000, rd_next};
			S_AXI_RRESP  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

	// control register; result bits are not stored so writes to them vanish
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctl_reg <= CTL_RESET;
		end else if (wr_hit && S_AXI_AWADDR == OFS_CONTROL) begin
			ctl_reg <= wbyte[5:0];
		end
	end

	// comparator interrupt enable
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cmp_en_reg <= 1'b0;
		end else if (wr_hit && S_AXI_AWADDR == OFS_ENABLES) begin
			cmp_en_reg <= wbyte[PERIPH_EN_BIT];
		end
	end

	// global and peripheral enables share one register
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			master_reg <= 2'h0;
		end else if (wr_hit && S_AXI_AWADDR == OFS_MASTER) begin
			master_reg <= wbyte[GLOBAL_EN_BIT:PERIPH_EN_BIT];
		end
	end

	// port direction; a set bit keeps the pin released
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			dir_reg <= DIRECTION_RESET;
		end else if (wr_hit && S_AXI_AWADDR == OFS_DIRECTION) begin
			dir_reg <= wbyte;
		end
	end

	// port output latch, hidden on the two pins while routing
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			latch_reg <= 8'h00;
		end else if (wr_hit && S_AXI_AWADDR == OFS_LATCH) begin
			latch_reg <= wbyte;
		end
	end

	// analog select; those pins read back as zero
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			analog_reg <= ANALOG_RESET;
		end else if (wr_hit && S_AXI_AWADDR == OFS_ANALOG) begin
			analog_reg <= wbyte;
		end
	end

	// flag: a persisting mismatch wins over a software clear in the same cycle
	// a clear written while the results still differ from the snapshot is lost,
	// so software must touch the control register before clearing
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			flag_reg <= 1'b0;
		end else if (dif.mismatch) begin
			flag_reg <= 1'b1;
		end else if (wr_hit && S_AXI_AWADDR == OFS_FLAGS) begin
			flag_reg <= wbyte[FLAG_BIT];
		end
	end

	// request gated by all three enables; software must mask it over mode changes
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			CMP_IRQ_REQ <= 1'b0;
		end else begin
			CMP_IRQ_REQ <= flag_reg && cmp_en_reg && master_reg[1] && master_reg[0];
		end
	end

	// analog switch controls decoded from the mode field
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			CMP_A_ON     <= 1'b0;
			CMP_B_ON     <= 1'b0;
			MODE_SEL     <= MODE_OFF;
			INPUT_SWITCH <= 1'b0;
			REF_TO_PLUS  <= 1'b0;
		end else begin
			CMP_A_ON     <= ctl_reg[CTL_MODE_HI:0] != MODE_OFF;
			CMP_B_ON     <= ctl_reg[CTL_MODE_HI:0] != MODE_OFF;
			MODE_SEL     <= ctl_reg[CTL_MODE_HI:0];
			INPUT_SWITCH <= (ctl_reg[CTL_MODE_HI:0] == MODE_MUX_FOUR)
				&& ctl_reg[CTL_IN_SWITCH];
			REF_TO_PLUS  <= ctl_reg[CTL_MODE_HI:0] == MODE_MUX_FOUR;
		end
	end

	// output enables from the direction bits, also while routing
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			PORT_F_OE <= 8'h00;
		end else begin
			PORT_F_OE <= ~dir_reg;
		end
	end

	// pin data: the routed results bypass every flop on purpose, so these two
	// bits follow the analog comparators with no clock delay
	assign route_on = mode_routes(ctl_reg[CTL_MODE_HI:0]);
	always_comb begin
		pin_drive = latch_reg;
		if (route_on) begin
			pin_drive[PIN_A_OUT] = CMP_A_RAW ^ ctl_reg[CTL_A_INVERT];
			pin_drive[PIN_B_OUT] = CMP_B_RAW ^ ctl_reg[CTL_B_INVERT];
		end
	end
	assign PORT_F_OUT = pin_drive;
endmodule

// [test/cmp_ctl_chk.sv]
`timescale 1ns/1ps
// watches bus acceptance, mode decode and the routed pin path
module cmp_ctl_chk (
	// clock and reset
	input wire logic       MCLK,
	input wire logic       RESET_N,
	// bus handshakes
	input wire logic       S_AXI_AWVALID,
	input wire logic       S_AXI_WVALID,
	input wire logic       S_AXI_AWREADY,
	input wire logic       S_AXI_BVALID,
	input wire logic       S_AXI_ARVALID,
	input wire logic       S_AXI_ARREADY,
	input wire logic       S_AXI_RVALID,
	// comparator side
	input wire logic       CMP_A_RAW,
	input wire logic       CMP_A_ON,
	input wire logic [2:0] MODE_SEL,
	input wire logic       INPUT_SWITCH,
	input wire logic       REF_TO_PLUS,
	input wire logic [7:0] PORT_F_OUT,
	input wire logic [7:0] PORT_F_OE
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RESET_N);
	// only the two routing modes hand the raw result to a pin
	wire logic route = MODE_SEL == 3'h3 || MODE_SEL == 3'h5;

	a_reset_mode: assert property ($rose(RESET_N) |-> MODE_SEL == 3'h7)
		else $error("mode not off after reset");
	a_off_power: assert property (CMP_A_ON == (MODE_SEL != 3'h7))
		else $error("power does not follow mode");
	a_ref_mode: assert property (REF_TO_PLUS == (MODE_SEL == 3'h6))
		else $error("reference outside its mode");
	a_switch_mode: assert property (INPUT_SWITCH |-> MODE_SEL == 3'h6)
		else $error("input switch outside its mode");
	a_pin_follow: assert property (route && $stable(MODE_SEL) && $changed(CMP_A_RAW)
		|-> $changed(PORT_F_OUT[1])) else $error("pin does not follow result");
	a_write_take: assert property (S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID
		&& !S_AXI_AWREADY |=> S_AXI_AWREADY) else $error("write not taken");
	a_read_take: assert property (S_AXI_ARVALID && !S_AXI_RVALID && !S_AXI_ARREADY
		|=> S_AXI_ARREADY) else $error("read not taken");
	a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read not answered");
	c_route: cover property (route && $changed(CMP_A_RAW));
	c_switch: cover property (INPUT_SWITCH);
	c_read: cover property (S_AXI_RVALID);
endmodule

bind cmp_ctl_top cmp_ctl_chk chk (.*);

// [test/cmp_analog_model.sv]
`timescale 1ns/1ps
// analog front end, two comparators; byte 0 feeds a, byte 1 feeds b
module cmp_analog_model (
	// input levels
	input  wire logic [15:0] plus,
	input  wire logic [15:0] minus,
	// raw results, settle a few ns after the levels, unrelated to the clock
	output wire logic        a_raw,
	output wire logic        b_raw
);
	assign #3 a_raw = plus[7:0] > minus[7:0];
	assign #3 b_raw = plus[15:8] > minus[15:8];
endmodule

// [test/test_dual_comparator_control.sv]
`timescale 1ns/1ps
// drives bus and analog levels, compares with a small register model
module test_dual_comparator_control import cmp_ctl_pkg::*;;
	logic        MCLK = 1'h0, RESET_N = 1'h0;
	logic [7:0]  S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00, PORT_F_IN = 8'h00;
	logic [31:0] S_AXI_WDATA = 32'h0;
	logic [3:0]  S_AXI_WSTRB = 4'hF;
	logic        S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
	logic        S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
	logic [15:0] plus = 16'h0000, minus = 16'h8080;
	wire logic   CMP_A_RAW, CMP_B_RAW, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
	wire logic   S_AXI_ARREADY, S_AXI_RVALID, CMP_A_ON, CMP_B_ON, INPUT_SWITCH;
	wire logic   REF_TO_PLUS, CMP_IRQ_REQ;
	wire logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
	wire logic [2:0]  MODE_SEL;
	wire logic [7:0]  PORT_F_OUT, PORT_F_OE;
	wire logic [31:0] S_AXI_RDATA;
	int          n_errors = 0, samples_checked = 0;
	// model: control bits, analog levels, software copy of the results
	logic [5:0]  ctl_m = 6'h07;
	logic        la = 1'h0, lb = 1'h0;
	logic [7:0]  d, lt, an;
	logic [31:0] v;
	logic [1:0]  r;
	wire logic [1:0] res_m = {lb ^ ctl_m[5], la ^ ctl_m[4]};

	cmp_ctl_top dut (.*);
	cmp_analog_model fe (.plus(plus), .minus(minus), .a_raw(CMP_A_RAW), .b_raw(CMP_B_RAW));

	always #20 MCLK = ~MCLK;

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t got %h expected %h", $time, g, e);
		end
	endtask
	// the extra edges let control outputs settle before anyone looks
	task automatic wr(input logic [7:0] a, input logic [7:0] x);
		logic aw_open;
		logic w_open;
		@(posedge MCLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= {24'h0, x};
		S_AXI_AWVALID <= 1'h1;
		S_AXI_WVALID <= 1'h1;
		S_AXI_BREADY <= 1'h1;
		aw_open = 1'h1;
		w_open = 1'h1;
		// each channel is released only at the edge that takes it
		while (aw_open || w_open) begin
			@(posedge MCLK);
			if (aw_open && S_AXI_AWREADY === 1'h1) begin
				aw_open = 1'h0;
				S_AXI_AWVALID <= 1'h0;
			end
			if (w_open && S_AXI_WREADY === 1'h1) begin
				w_open = 1'h0;
				S_AXI_WVALID <= 1'h0;
			end
		end
		do @(posedge MCLK); while (S_AXI_BVALID !== 1'h1);
		r = S_AXI_BRESP;
		S_AXI_BREADY <= 1'h0;
		repeat (2) @(posedge MCLK);
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge MCLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'h1;
		S_AXI_RREADY <= 1'h1;
		do @(posedge MCLK); while (S_AXI_ARREADY !== 1'h1);
		S_AXI_ARVALID <= 1'h0;
		do @(posedge MCLK); while (S_AXI_RVALID !== 1'h1);
		v = S_AXI_RDATA;
		r = S_AXI_RRESP;
		S_AXI_RREADY <= 1'h0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk(v, {24'h0, e});
		chk(32'(r), 32'(RESP_OKAY));
	endtask
	// new analog levels, then time for the synchroniser and flag
	task automatic lv(input logic a, input logic b);
		la = a;
		lb = b;
		plus <= {b ? 8'hC8 : 8'h32, a ? 8'hC8 : 8'h32};
		repeat (6) @(posedge MCLK);
	endtask
	task automatic complete_run;
		$display("mismatches %0d comparisons %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		#400000;
		n_errors++;
		complete_run();
	end

	initial begin
		void'($urandom(32'h1f96));
		repeat (3) @(posedge MCLK);
		RESET_N <= 1'h1;
		rchk(OFS_CONTROL, 8'h07);
		rchk(OFS_DIRECTION, 8'hFE);
		rchk(OFS_ANALOG, 8'h7E);
		rd(8'h20);
		chk(32'(r), 32'(RESP_SLVERR));
		wr(8'h20, 8'h55);
		chk(32'(r), 32'(RESP_SLVERR));
		// all eight modes, random polarity, result bits written as ones; irq kept off
		for (int m = 0; m < 8; m++) begin
			d = {2'h3, 3'($urandom), 3'(m)};
			wr(OFS_CONTROL, d);
			ctl_m = d[5:0];
			lv(m[0], m[1]);
			rchk(OFS_CONTROL, {res_m, ctl_m});
			chk(32'(MODE_SEL), 32'(m));
			chk(32'(REF_TO_PLUS), 32'(m == 6));
			chk(32'(INPUT_SWITCH), 32'(m == 6 && d[3]));
			chk(32'({CMP_B_ON, CMP_A_ON}), m == 7 ? 32'h0 : 32'h3);
		end
		// change flag: persists until a control access ends the mismatch
		wr(OFS_MASTER, 8'hC0);
		wr(OFS_ENABLES, 8'h40);
		rchk(OFS_CONTROL, {res_m, ctl_m});
		wr(OFS_FLAGS, 8'h00);
		lv(~la, lb);
		rchk(OFS_FLAGS, 8'h40);
		chk(32'(CMP_IRQ_REQ), 32'h1);
		wr(OFS_FLAGS, 8'h00);
		rchk(OFS_FLAGS, 8'h40);
		rchk(OFS_CONTROL, {res_m, ctl_m});
		wr(OFS_FLAGS, 8'h00);
		rchk(OFS_FLAGS, 8'h00);
		chk(32'(CMP_IRQ_REQ), 32'h0);
		wr(OFS_FLAGS, 8'h40);
		rchk(OFS_FLAGS, 8'h40);
		chk(32'(CMP_IRQ_REQ), 32'h1);
		wr(OFS_MASTER, 8'h40);
		chk(32'(CMP_IRQ_REQ), 32'h0);
		wr(OFS_FLAGS, 8'h00);
		// routed pins: mode 0 keeps the latch, 3 and 5 show the results
		wr(OFS_DIRECTION, 8'h00);
		lt = 8'($urandom);
		wr(OFS_LATCH, lt);
		for (int i = 0; i < 3; i++) begin
			d = {3'h0, 2'($urandom), 3'(i * 2 + (i > 0))};
			wr(OFS_CONTROL, d);
			ctl_m = d[5:0];
			lv(~la, ~lb);
			chk(PORT_F_OUT, i > 0 ? {lt[7:3], res_m, lt[0]} : lt);
			chk(PORT_F_OE, 8'hFF);
		end
		// result changes set the flag even with the global enable off
		rchk(OFS_FLAGS, 8'h40);
		chk(32'(CMP_IRQ_REQ), 32'h0);
		wr(OFS_DIRECTION, 8'h06);
		chk(PORT_F_OE, 8'hF9);
		PORT_F_IN <= 8'($urandom);
		an = 8'($urandom);
		wr(OFS_ANALOG, an);
		rchk(OFS_PORT_READ, PORT_F_IN & ~an);
		// a write with byte lane 0 off must leave the latch alone
		S_AXI_WSTRB <= 4'hE;
		wr(OFS_LATCH, ~lt);
		chk(32'(r), 32'(RESP_OKAY));
		S_AXI_WSTRB <= 4'hF;
		rchk(OFS_LATCH, lt);
		// mid-run reset puts the control bits back, results keep following the levels
		RESET_N <= 1'h0;
		repeat (2) @(posedge MCLK);
		RESET_N <= 1'h1;
		ctl_m = 6'h07;
		rchk(OFS_CONTROL, {res_m, ctl_m});
		chk(32'(MODE_SEL), 32'(MODE_OFF));
		chk(PORT_F_OE, 8'h01);
		complete_run();
	end
endmodule
